// [common/ipc_map.svh]
// ipc_map.svh: offsets, field values and timing counts for the checked
// two-wire slave transfer block and its bus master.
// assumes: included by bare name after the package; clock of 100 MHz.
`ifndef IPC_MAP_SVH
`define IPC_MAP_SVH

// ----------------------------------------------------------------------
// bus addressing
// ----------------------------------------------------------------------
`define IPC_SLV_ADDR   7'h50
`define IPC_ADDR_WR    8'hA0
`define IPC_ADDR_RD    8'hA1

// ----------------------------------------------------------------------
// checked transfer framing
// ----------------------------------------------------------------------
`define IPC_CRC_POLY   8'h07
`define IPC_CRC_INIT   8'h00
`define IPC_CAB        8'h00
`define IPC_PEC_RD_MAX 8'h80
`define IPC_PEC_WR_MAX 8'h04
`define IPC_ROW_BYTES  4

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define IPC_CLK_NS     10
`define IPC_TW_NS      10000000
`define IPC_TW_CYC     (`IPC_TW_NS / `IPC_CLK_NS)
`define IPC_SCL_NS     10000
`define IPC_QTR_CYC    (`IPC_SCL_NS / 4 / `IPC_CLK_NS)

`endif

// [common/ipc_pkg.sv]
// ipc_pkg.sv: state types and the check-value helper for both ends.
// assumes: compiled before the interface and the design modules.
package ipc_pkg;
  `include "ipc_map.svh"

  // ----------------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    IPC_D_IDLE = 2'b00,
    IPC_D_RECV = 2'b01,
    IPC_D_SEND = 2'b10
  } ipc_dst_t;

  typedef enum logic [1:0] {
    IPC_H_IDLE  = 2'b00,
    IPC_H_START = 2'b01,
    IPC_H_BYTE  = 2'b10,
    IPC_H_STOP  = 2'b11
  } ipc_hst_t;

  // ----------------------------------------------------------------------
  // crc-8, msb first, one whole byte per call
  // ----------------------------------------------------------------------
  function automatic logic [7:0] ipc_crc8(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ `IPC_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
endpackage

// [common/ipc_if.sv]
// ipc_if.sv: the two-wire link between the bus master and the slave.
// assumes: master drives the clock push-pull; data is open drain with a
// pullup, so the line is low whenever either end enables its driver.
interface ipc_if;
  logic scl;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  wire  sda;

  // wired-and of the two open-drain drivers
  assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));

  modport dev  (input scl, input sda, output d_sda_o, output d_sda_oe);
  modport host (output scl, output h_sda_o, output h_sda_oe, input sda);
endinterface

// [design/ipc_dev.sv]
// ipc_dev.sv: slave end of the two-wire link with checked transfers,
// a 256-byte memory, row staging and a nonvolatile write busy window.
// assumes: one clock i_clk; link pins are asynchronous and are
// synchronised here; i_pec_en comes from logic on the same clock.
`include "ipc_map.svh"

// Operation
// - master acks to continue, nacks last, stops
// - read pointer wraps within table, ffh to 80h
// - checked read: address, memory address, count
// - checked read returns 1 to 128 bytes
// - send data while acked, then one crc byte
// - read crc over address, count, data, msb first; here the crc starts at the memory address, slave address left out
// - crc polynomial is x8 + x2 + x + 1
// - master may drop data on crc mismatch
// - checked write: address, memory address, count
// - acknowledge every data byte of checked write
// - checked write carries at most 4 bytes
// - master sends crc, add-on byte, then stop
// - ack add-on byte only when crc matches
// - write crc over address, count, data, msb first; here the crc starts at the memory address, slave address left out
// - answer only address 1010000 while selected
// - write bytes wrap inside one 4-byte row
// - no address ack while row commit runs
module ipc_dev import ipc_pkg::*; #(
  parameter int unsigned TW_CYC = `IPC_TW_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_pec_en,
  input  wire logic i_module_chip_select_pin,
  output logic      o_busy,
  output logic      o_crc_err,
  ipc_if.dev        bus
);
  localparam int BW = $clog2(TW_CYC + 1);

  // ----------------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------------
  if (TW_CYC < 1) begin : g_bad_tw
    $error("ipc_dev: TW_CYC must be at least 1");
  end

  ipc_dst_t       st_r;
  logic [2:0]     scl_q;
  logic [2:0]     sda_q;
  logic [1:0]     sel_q;
  logic [3:0]     bc_r;
  logic [7:0]     sh_r;
  logic [7:0]     idx_r;
  logic           rw_r;
  logic           pec_r;
  logic [7:0]     ptr_r;
  logic [7:0]     cnt_r;
  logic [7:0]     sent_r;
  logic [7:0]     crc_r;
  logic [7:0]     rxcrc_r;
  logic           crc_ok_r;
  logic           mack_r;
  logic           oe_r;
  logic           sdo_r;
  logic [3:0]     dirty_r;
  logic [7:0]     row_r [`IPC_ROW_BYTES];
  logic [7:0]     mem_r [256];
  logic [BW-1:0]  busy_r;

  // ----------------------------------------------------------------------
  // pin synchronisers; stage 0 is read only by stage 1
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      sel_q <= 2'h3;
    end else begin
      scl_q <= {scl_q[1:0], bus.scl};
      sda_q <= {sda_q[1:0], bus.sda};
      sel_q <= {sel_q[0], i_module_chip_select_pin};
    end
  end

  // bus conditions seen on the synchronised pair
  wire scl_c   = scl_q[1];
  wire scl_p   = scl_q[2];
  wire sda_c   = sda_q[1];
  wire sda_p   = sda_q[2];
  wire start_w = scl_c & scl_p & sda_p & ~sda_c;
  wire stop_w  = scl_c & scl_p & ~sda_p & sda_c;
  wire rise_w  = scl_c & ~scl_p;
  wire fall_w  = ~scl_c & scl_p;
  wire sel_w   = ~sel_q[1];   // pin high deselects the part

  // ----------------------------------------------------------------------
  // byte decode for the receive direction
  // ----------------------------------------------------------------------
  wire [7:0] hdr_w    = pec_r ? 8'h03 : 8'h02;
  wire [7:0] dix_w    = idx_r - hdr_w;
  wire       past_w   = idx_r >= hdr_w;
  wire       addr_ok  = (sh_r[7:1] == `IPC_SLV_ADDR) & sel_w
                        & ~o_busy;
  wire       is_cnt_w = pec_r & (idx_r == 8'h02);
  wire       is_dat_w = past_w & (~pec_r | (dix_w < cnt_r));
  wire       is_crc_w = pec_r & past_w & (dix_w == cnt_r);
  wire       is_cab_w = pec_r & past_w & (dix_w == cnt_r + 8'h01);
  wire       cab_ok_w = rxcrc_r == crc_r;
  wire [7:0] crc_rx_w = ipc_crc8(crc_r, sh_r);
  wire       ack_w    = (idx_r == 8'h00) ? addr_ok :
                        ((idx_r == 8'h01) | ~pec_r | is_cnt_w | is_dat_w
                         | is_crc_w | (is_cab_w & cab_ok_w));
  wire       rx_end_w = (st_r == IPC_D_RECV) & fall_w & (bc_r == 4'h8);
  wire       rx_rel_w = (st_r == IPC_D_RECV) & fall_w & (bc_r == 4'h9);
  wire       wr_byte  = rx_end_w & ~rw_r & is_dat_w;

  // ----------------------------------------------------------------------
  // byte select for the send direction
  // ----------------------------------------------------------------------
  wire       tx_crc_w = pec_r & (sent_r == cnt_r);
  wire [7:0] txb_w    = tx_crc_w ? crc_r : mem_r[ptr_r];
  wire [7:0] ptr_inc  = {ptr_r[7], ptr_r[6:0] + 7'h01};
  wire [7:0] ptr_row  = {ptr_r[7:2], ptr_r[1:0] + 2'h1};
  wire       ld_w     = (rx_rel_w & rw_r & (idx_r == 8'h00))
                        | ((st_r == IPC_D_SEND) & fall_w & (bc_r == 4'h9)
                           & mack_r);
  wire       commit_w = stop_w & (|dirty_r)
                        & (~pec_r | crc_ok_r);

  // ----------------------------------------------------------------------
  // transfer sequencer; start and stop override any bit in flight
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r      <= IPC_D_IDLE;
      bc_r      <= 4'h0;
      sh_r      <= 8'h00;
      idx_r     <= 8'h00;
      rw_r      <= 1'b0;
      pec_r     <= 1'b0;
      ptr_r     <= 8'h00;
      cnt_r     <= 8'h00;
      sent_r    <= 8'h00;
      crc_r     <= `IPC_CRC_INIT;
      rxcrc_r   <= 8'h00;
      crc_ok_r  <= 1'b0;
      mack_r    <= 1'b0;
      oe_r      <= 1'b0;
      o_crc_err <= 1'b0;
    end else begin
      o_crc_err <= 1'b0;
      if (start_w) begin
        st_r     <= IPC_D_RECV;
        bc_r     <= 4'h0;
        idx_r    <= 8'h00;
        oe_r     <= 1'b0;
        pec_r    <= i_pec_en;
        crc_ok_r <= 1'b0;
      end else if (stop_w) begin
        st_r <= IPC_D_IDLE;
        oe_r <= 1'b0;
      end else if (ld_w) begin
        st_r <= IPC_D_SEND;
        sh_r <= txb_w;
        oe_r <= ~txb_w[7];
        bc_r <= 4'h0;
        if (!tx_crc_w) begin
          crc_r  <= ipc_crc8(crc_r, txb_w);
          ptr_r  <= ptr_inc;
          sent_r <= sent_r + 8'h01;
        end
      end else begin
        case (st_r)
          IPC_D_RECV: begin
            if (rise_w && bc_r < 4'h8) begin
              sh_r <= {sh_r[6:0], sda_c};
              bc_r <= bc_r + 4'h1;
            end else if (rx_end_w) begin
              bc_r <= 4'h9;
              oe_r <= ack_w;
              if (!ack_w) begin
                st_r <= IPC_D_IDLE;  // nacked byte (address, byte past the add-on byte, or check refused): wait for a start
              end
              if (idx_r == 8'h00) begin
                rw_r   <= sh_r[0];
                sent_r <= 8'h00;
              end else if (idx_r == 8'h01) begin
                ptr_r <= sh_r;
                crc_r <= ipc_crc8(`IPC_CRC_INIT, sh_r);
              end else begin
                if (is_cnt_w) begin
                  cnt_r <= sh_r;
                end
                if (pec_r && (is_cnt_w || is_dat_w)) begin
                  crc_r <= crc_rx_w;
                end
                if (is_dat_w) begin
                  ptr_r <= ptr_row;
                end
                if (is_crc_w) begin
                  rxcrc_r <= sh_r;
                end
                if (is_cab_w) begin
                  crc_ok_r  <= cab_ok_w;
                  o_crc_err <= ~cab_ok_w;
                end
              end
            end else if (rx_rel_w) begin
              bc_r <= 4'h0;
              oe_r <= 1'b0;
              if (idx_r != 8'hFF) begin
                idx_r <= idx_r + 8'h01;
              end
            end
          end
          IPC_D_SEND: begin
            if (rise_w && bc_r < 4'h8) begin
              bc_r <= bc_r + 4'h1;
            end else if (rise_w && bc_r == 4'h8) begin
              mack_r <= ~sda_c;
              bc_r   <= 4'h9;
            end else if (fall_w && bc_r < 4'h8) begin
              sh_r <= {sh_r[6:0], 1'b0};
              oe_r <= ~sh_r[6];
            end else if (fall_w && bc_r == 4'h8) begin
              oe_r <= 1'b0;  // let the master answer
            end else if (fall_w && bc_r == 4'h9) begin
              st_r <= IPC_D_IDLE;  // nack ends the read
            end
          end
          default: begin
            oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // row staging; written only at stop so a bad check leaves memory as is
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dirty_r <= 4'h0;
      for (int i = 0; i < `IPC_ROW_BYTES; i++) begin
        row_r[i] <= 8'h00;
      end
      for (int i = 0; i < 256; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else begin
      if (wr_byte) begin
        row_r[ptr_r[1:0]]   <= sh_r;
        dirty_r[ptr_r[1:0]] <= 1'b1;
      end
      if (commit_w) begin
        for (int i = 0; i < `IPC_ROW_BYTES; i++) begin
          if (dirty_r[i]) begin
            mem_r[{ptr_r[7:2], 2'(i)}] <= row_r[i];
          end
        end
      end
      if (stop_w) begin
        dirty_r <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // commit window; address is refused until it runs out
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_r <= '0;
      o_busy <= 1'b0;
      sdo_r  <= 1'b0;
    end else begin
      sdo_r <= 1'b0;  // open drain: only ever pulls low
      if (commit_w) begin
        busy_r <= BW'(TW_CYC);
        o_busy <= 1'b1;
      end else if (busy_r != '0) begin
        busy_r <= busy_r - BW'(1);
        if (busy_r == BW'(1)) begin
          o_busy <= 1'b0;
        end
      end
    end
  end

  assign bus.d_sda_oe = oe_r;
  assign bus.d_sda_o  = sdo_r;
endmodule

// [design/ipc_host.sv]
// ipc_host.sv: bus master end; runs one plain or checked read or write
// per command and reports data bytes and an overall pass flag.
// assumes: one clock i_clk; returning data line is asynchronous.
`include "ipc_map.svh"

module ipc_host import ipc_pkg::*; #(
  parameter int unsigned QTR_CYC = `IPC_QTR_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_go,
  input  wire logic        i_rd,
  input  wire logic        i_pec,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_cnt,
  input  wire logic [31:0] i_wdata,
  output logic             o_ready,
  output logic [7:0]       o_rdata,
  output logic             o_rvalid,
  output logic             o_done,
  output logic             o_ok,
  ipc_if.host              bus
);
  // ----------------------------------------------------------------------
  // parameter check; quarter must outlast the two-stage synchroniser
  // ----------------------------------------------------------------------
  if (QTR_CYC < 4 || QTR_CYC > 65535) begin : g_bad_qtr
    $error("ipc_host: QTR_CYC out of range");
  end

  ipc_hst_t    st_r;
  logic [15:0] q_r;
  logic [1:0]  ph_r;
  logic [3:0]  bit_r;
  logic [7:0]  idx_r;
  logic        rxp_r;
  logic        rd_r;
  logic        pec_r;
  logic [7:0]  addr_r;
  logic [7:0]  cnt_r;
  logic [31:0] wd_r;
  logic [7:0]  sh_r;
  logic [7:0]  crc_r;
  logic        ack_r;
  logic        scl_r;
  logic        oe_r;
  logic        sdo_r;
  logic [1:0]  sda_q;

  // ----------------------------------------------------------------------
  // command screening and byte selection
  // ----------------------------------------------------------------------
  wire [7:0] lim_w    = (i_rd & i_pec) ? `IPC_PEC_RD_MAX :
                        (i_rd ? 8'hFF : `IPC_PEC_WR_MAX);
  wire       cmd_ok   = (i_cnt != 8'h00) & (i_cnt <= lim_w);
  wire       tick_w   = q_r == 16'(QTR_CYC - 1);
  wire       is_tx    = ~rxp_r | (idx_r == 8'h00);
  wire [7:0] dix_w    = idx_r - (pec_r ? 8'h03 : 8'h02);
  wire [7:0] wbyte_w  = wd_r[{dix_w[1:0], 3'h0} +: 8];
  wire [7:0] txb_w    = rxp_r ? `IPC_ADDR_RD :
                        (idx_r == 8'h00) ? `IPC_ADDR_WR :
                        (idx_r == 8'h01) ? addr_r :
                        (pec_r & idx_r == 8'h02) ? cnt_r :
                        (dix_w < cnt_r) ? wbyte_w :
                        (dix_w == cnt_r) ? crc_r : `IPC_CAB;
  wire [7:0] wr_last  = cnt_r + (pec_r ? 8'h04 : 8'h01);
  wire [7:0] hd_last  = pec_r ? 8'h02 : 8'h01;
  wire [7:0] rx_last  = cnt_r + {7'h00, pec_r};
  wire       fold_w   = pec_r & (is_tx ? (~rxp_r & idx_r != 8'h00
                                          & idx_r <= cnt_r + 8'h02)
                                       : (idx_r <= cnt_r));
  wire [7:0] bval_w   = is_tx ? txb_w : sh_r;
  wire       my_ack   = idx_r < rx_last;
  wire       sda_c    = sda_q[1];

  // synchroniser; stage 0 is read only by stage 1
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sda_q <= 2'h3;
    end else begin
      sda_q <= {sda_q[0], bus.sda};
    end
  end

  // ----------------------------------------------------------------------
  // bit engine: quarters end with sda set, scl high, sample, scl low
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= IPC_H_IDLE;
      {q_r, ph_r, bit_r, idx_r} <= '0;
      {rxp_r, rd_r, pec_r, ack_r, oe_r, sdo_r} <= '0;
      {addr_r, cnt_r, wd_r, sh_r} <= '0;
      crc_r    <= `IPC_CRC_INIT;
      scl_r    <= 1'b1;
      o_ready  <= 1'b1;
      o_rdata  <= 8'h00;
      o_rvalid <= 1'b0;
      o_done   <= 1'b0;
      o_ok     <= 1'b0;
    end else begin
      o_rvalid <= 1'b0;
      o_done   <= 1'b0;
      if (st_r != IPC_H_IDLE) begin
        q_r <= tick_w ? 16'h0000 : q_r + 16'h0001;
        if (tick_w) begin
          ph_r <= ph_r + 2'h1;
        end
      end
      case (st_r)
        IPC_H_IDLE: begin
          if (i_go && cmd_ok) begin
            {rd_r, pec_r, addr_r, cnt_r, wd_r} <=
              {i_rd, i_pec, i_addr, i_cnt, i_wdata};
            {idx_r, rxp_r, q_r, ph_r} <= '0;
            crc_r   <= `IPC_CRC_INIT;
            o_ready <= 1'b0;
            st_r    <= IPC_H_START;
          end else if (i_go) begin
            o_done <= 1'b1;  // illegal count is refused outright
            o_ok   <= 1'b0;
          end
        end
        IPC_H_START: if (tick_w) begin
          case (ph_r)
            2'h0: oe_r  <= 1'b0;
            2'h1: scl_r <= 1'b1;
            2'h2: oe_r  <= 1'b1;
            default: begin
              scl_r <= 1'b0;
              bit_r <= 4'h0;
              st_r  <= IPC_H_BYTE;
            end
          endcase
        end
        IPC_H_BYTE: if (tick_w) begin
          case (ph_r)
            2'h0: begin
              if (is_tx && bit_r == 4'h0) begin
                sh_r <= txb_w;
              end
              oe_r <= is_tx ? ((bit_r != 4'h8) &
                               ~((bit_r == 4'h0) ? txb_w[7] : sh_r[7]))
                            : ((bit_r == 4'h8) & my_ack);
            end
            2'h1: scl_r <= 1'b1;
            2'h2: begin
              if (!is_tx && bit_r != 4'h8) begin
                sh_r <= {sh_r[6:0], sda_c};
              end
              if (bit_r == 4'h8) begin
                ack_r <= ~sda_c;
              end
            end
            default: begin
              scl_r <= 1'b0;
              bit_r <= bit_r + 4'h1;
              if (is_tx && bit_r != 4'h8) begin
                sh_r <= {sh_r[6:0], 1'b0};
              end
              if (bit_r == 4'h8) begin
                bit_r <= 4'h0;
                idx_r <= idx_r + 8'h01;
                if (fold_w) begin
                  crc_r <= ipc_crc8(crc_r, bval_w);
                end
                if (is_tx) begin
                  if (!ack_r) begin
                    o_ok <= 1'b0;
                    st_r <= IPC_H_STOP;
                  end else if (!rxp_r && !rd_r && idx_r == wr_last) begin
                    o_ok <= 1'b1;
                    st_r <= IPC_H_STOP;
                  end else if (!rxp_r && rd_r && idx_r == hd_last) begin
                    rxp_r <= 1'b1;
                    idx_r <= 8'h00;
                    st_r  <= IPC_H_START;  // repeated start for data
                  end
                end else begin
                  if (idx_r <= cnt_r) begin
                    o_rdata  <= sh_r;
                    o_rvalid <= 1'b1;
                  end
                  if (idx_r == rx_last) begin
                    o_ok <= ~pec_r | (sh_r == crc_r);
                    st_r <= IPC_H_STOP;
                  end
                end
              end
            end
          endcase
        end
        IPC_H_STOP: if (tick_w) begin
          case (ph_r)
            2'h0: oe_r  <= 1'b1;
            2'h1: scl_r <= 1'b1;
            2'h2: oe_r  <= 1'b0;
            default: begin
              st_r    <= IPC_H_IDLE;
              o_done  <= 1'b1;
              o_ready <= 1'b1;
            end
          endcase
        end
        default: st_r <= IPC_H_IDLE;
      endcase
    end
  end

  assign bus.scl      = scl_r;
  assign bus.h_sda_oe = oe_r;
  assign bus.h_sda_o  = sdo_r;
endmodule

// [testbench/ipc_chk.sv]
// ipc_chk.sv: wire-level assertions on the two-wire link.
// assumes: beside the link interface, host QTR_CYC of 4, one clock.
module ipc_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_h_sda_o,
  input wire logic i_h_sda_oe,
  input wire logic i_d_sda_o,
  input wire logic i_d_sda_oe,
  input wire logic i_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // open drain: drivers only ever pull low
  dev_pull_low_a: assert property (i_d_sda_oe |-> !i_d_sda_o)
    else $error("slave data driver not low");
  host_pull_low_a: assert property (i_h_sda_oe |-> !i_h_sda_o)
    else $error("master data driver not low");
  // slave moves data only while the clock is low
  dev_moves_low_a: assert property ($changed(i_d_sda_oe) |-> !i_scl)
    else $error("slave data changed with clock high");
  // synchroniser lag: no slave change right after a clock edge
  dev_sync_lag_a: assert property (
    $changed(i_d_sda_oe) |-> !$past(i_scl, 2))
    else $error("slave data changed too soon after clock fall");
  host_holds_a: assert property (
    $rose(i_scl) |=> $stable(i_h_sda_oe)[*2])
    else $error("master data moved early in clock high");
  scl_high_min_a: assert property ($rose(i_scl) |-> i_scl[*4])
    else $error("clock high phase too short");
  idle_rst_a: assert property (
    $fell(i_rst) |-> !i_d_sda_oe && !i_h_sda_oe && i_scl)
    else $error("link not idle after reset");
  // any enabled driver must show low on the resolved line
  wire_and_a: assert property ((i_d_sda_oe || i_h_sda_oe) |-> !i_sda)
    else $error("resolved data line not low");
endmodule

// [testbench/i2c_slave_pec_transfer_tb.sv]
// bench: both link ends back to back, checked and plain transfers.
// assumes: short commit window and bit time set through parameters.
module i2c_slave_pec_transfer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // stimulus and model
  // ----------------------------------------------------------------
  localparam int TW = 400; // long enough to poll into the busy window
  logic        i_clk = 1'h0, i_rst = 1'h1, i_go = 1'h0, i_rd = 1'h0;
  logic        i_pec = 1'h0, desel = 1'h0;
  logic [7:0]  i_addr = 8'h00, i_cnt = 8'h00, a, n, o_rdata;
  logic [31:0] i_wdata = 32'h0;
  logic        o_ready, o_rvalid, o_done, o_ok, o_busy, o_crc_err;
  logic [7:0]  mem [256];
  logic [7:0]  bad_cnt [4] = '{8'h00, 8'h81, 8'h05, 8'h00};
  int          err_total = 0, total_checks = 0, seed = 63;

  always #5 i_clk = ~i_clk;

  ipc_if link ();
  ipc_dev #(.TW_CYC(TW)) ipc_dev_i (.i_clk(i_clk), .i_rst(i_rst),
    .i_pec_en(i_pec), .i_module_chip_select_pin(desel), .o_busy(o_busy),
    .o_crc_err(o_crc_err), .bus(link));
  ipc_host #(.QTR_CYC(4)) ipc_host_i (.i_clk(i_clk), .i_rst(i_rst),
    .i_go(i_go), .i_rd(i_rd), .i_pec(i_pec), .i_addr(i_addr),
    .i_cnt(i_cnt), .i_wdata(i_wdata), .o_ready(o_ready),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_done(o_done),
    .o_ok(o_ok), .bus(link));
  ipc_chk ipc_chk_i (.i_clk(i_clk), .i_rst(i_rst), .i_scl(link.scl),
    .i_h_sda_o(link.h_sda_o), .i_h_sda_oe(link.h_sda_oe),
    .i_d_sda_o(link.d_sda_o), .i_d_sda_oe(link.d_sda_oe),
    .i_sda(link.sda));

  task automatic wrap_up();
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one command; the model is updated only when the write should land
  task automatic xfer(input logic rd, pec, cs, input logic [7:0] a0, c,
                      input logic [31:0] w, input logic e_ok, input int gap);
    logic [7:0] p;
    p = a0;
    i_rd <= rd;
    i_pec <= pec;
    desel <= cs;
    i_addr <= a0;
    i_cnt <= c;
    i_wdata <= w;
    if (!rd && e_ok) begin
      for (int j = 0; j < c; j++) begin
        mem[{a0[7:2], a0[1:0] + 2'(j)}] = w[8 * j +: 8]; // row wrap
      end
    end
    @(posedge i_clk);
    i_go <= 1'h1;
    @(posedge i_clk);
    i_go <= 1'h0;
    while (o_done !== 1'h1) begin
      @(posedge i_clk);
      check(8'(o_crc_err), 8'h00);
      if (o_rvalid === 1'h1) begin
        check(o_rdata, mem[p]);
        p = {p[7], p[6:0] + 7'h01}; // stays inside its table half
      end
    end
    check(8'(o_ok), 8'(e_ok));
    if (!rd && e_ok) check(8'(o_busy), 8'h01);
    while (o_ready !== 1'h1) @(posedge i_clk);
    repeat (gap) @(posedge i_clk);
  endtask

  // watchdog: whole run is about 40k cycles
  initial begin
    #600000;
    err_total++;
    wrap_up();
  end

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'h0;
    @(posedge i_clk);
    xfer(0, 1, 0, 8'h80, 4, $random(seed), 1, TW + 20);
    xfer(0, 1, 0, 8'hFC, 4, $random(seed), 1, 0);
    xfer(0, 1, 0, 8'hFC, 1, $random(seed), 0, TW + 20);
    for (int j = 0; j < 4; j++) begin
      xfer(j < 2, 1, 0, 8'h10, bad_cnt[j], 0, 0, 4);
    end
    xfer(1, 1, 0, 8'hC0, 128, 0, 1, 20);
    xfer(0, 1, 1, 8'h40, 1, $random(seed), 0, 20);
    xfer(0, 0, 0, 8'h42, 4, $random(seed), 1, TW + 20);
    xfer(1, 0, 0, 8'h40, 4, 0, 1, 20);
    repeat (4) begin
      a = 8'($random(seed)) & 8'hFC;
      n = 8'h01 + (8'($random(seed)) & 8'h03);
      xfer(0, 1, 0, a, n, $random(seed), 1, TW + 20);
      xfer(1, 1, 0, a, n, 0, 1, 20);
    end
    wrap_up();
  end
endmodule
